// ==== hdl/sbc_bank_ctrl.sv ====
/*
  Per-bank command-legality state machines of a two-bank synchronous DRAM,
  with a shared burst engine and a read-beat stream through a FIFO.
  Assumes command pins arrive from outside the clk domain; rst_n asynchronous.
*/
`timescale 1ns/1ps
module sbc_bank_ctrl #(
  parameter int BURST_LEN = sbc_pkg::SBC_DEF_BURST_LEN,
  parameter int CAS_LAT   = sbc_pkg::SBC_DEF_CAS_LAT
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  cke_pin,
  input  wire logic                                  cs_n_pin,
  input  wire logic                                  ras_n_pin,
  input  wire logic                                  cas_n_pin,
  input  wire logic                                  we_n_pin,
  input  wire logic [sbc_pkg::SBC_ADDR_W-1:0]        addr_pin,
  input  wire logic                                  rd_ready,
  output logic                                       rd_valid,
  output logic [sbc_pkg::SBC_COL_W:0]                rd_data,
  output logic [sbc_pkg::SBC_NUM_BANKS*4-1:0]        bank_state,
  output logic                                       illegal_cmd,
  output logic                                       power_down,
  output logic                                       self_refresh,
  output logic [sbc_pkg::SBC_ADDR_W-1:0]             mode_reg,
  output logic                                       burst_busy
);
  localparam int NB = sbc_pkg::SBC_NUM_BANKS;
  localparam int PW = sbc_pkg::SBC_ADDR_W + 5;
  localparam int DW = sbc_pkg::SBC_COL_W + 1;

  // two-stage pin synchroniser; meta stage feeds only the second stage
  logic [PW-1:0] pin_meta_q;
  logic [PW-1:0] pin_s_q;
  logic          cke_prev_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // clock enable high and all strobes high: a deselect until real pins arrive
      pin_meta_q <= {5'h1F, {sbc_pkg::SBC_ADDR_W{1'b0}}};
      pin_s_q    <= {5'h1F, {sbc_pkg::SBC_ADDR_W{1'b0}}};
      cke_prev_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, addr_pin};
      pin_s_q    <= pin_meta_q;
      cke_prev_q <= pin_s_q[PW-1];
    end
  end

  wire                           cke_s  = pin_s_q[PW-1];
  wire                           cs_s   = pin_s_q[PW-2];
  wire                           ras_s  = pin_s_q[PW-3];
  wire                           cas_s  = pin_s_q[PW-4];
  wire                           we_s   = pin_s_q[PW-5];
  wire [sbc_pkg::SBC_ADDR_W-1:0] addr_s = pin_s_q[sbc_pkg::SBC_ADDR_W-1:0];

  // command decode; commands only count when clock enable was high one edge before
  wire cmd_ok = cke_prev_q;
  wire sel    = !cs_s;
  wire device_deselect_cmd = cs_s;
  wire nop_cmd        = sel &&  ras_s &&  cas_s &&  we_s;
  wire burst_stop_cmd = sel &&  ras_s &&  cas_s && !we_s;
  wire read_cmd       = sel &&  ras_s && !cas_s &&  we_s;
  wire write_cmd      = sel &&  ras_s && !cas_s && !we_s;
  wire bank_activate_cmd      = sel && !ras_s &&  cas_s &&  we_s;
  wire precharge_cmd          = sel && !ras_s &&  cas_s && !we_s;
  wire refresh_cmd            = sel && !ras_s && !cas_s &&  we_s;
  wire mode_register_load_cmd = sel && !ras_s && !cas_s && !we_s;
  wire bank_select_bit  = addr_s[sbc_pkg::SBC_BANK_BIT];
  wire autoprecharge_bit = addr_s[sbc_pkg::SBC_AP_BIT];
  wire precharge_both_cmd = precharge_cmd && autoprecharge_bit;
  wire quiet_cmd = device_deselect_cmd || nop_cmd || burst_stop_cmd;
  wire rw_cmd    = read_cmd || write_cmd;
  wire [sbc_pkg::SBC_COL_W-1:0] col_s = addr_s[sbc_pkg::SBC_COL_W-1:0];

  // shared burst engine: one data bus, so a new burst on either bank ends the old one
  logic                        busy_q;
  logic                        rd_burst_q;
  logic                        bbank_q;
  logic [sbc_pkg::SBC_COL_W-1:0] col_q;
  logic [7:0]                  cnt_q;
  logic                        fifo_in_ready;
  logic                        pipe_v_q [CAS_LAT];
  logic [DW-1:0]               pipe_d_q [CAS_LAT];

  logic [3:0] st_w    [NB];
  logic       ill_w   [NB];
  logic       start_w [NB];
  logic       stop_w  [NB];
  logic       done_w  [NB];

  wire all_idle  = (st_w[0] == sbc_pkg::SBC_IDLE) && (st_w[1] == sbc_pkg::SBC_IDLE);
  wire start_any = start_w[0] || start_w[1];
  wire stop_any  = stop_w[0] || stop_w[1];
  wire ill_glob  = cmd_ok && (refresh_cmd || mode_register_load_cmd) && !all_idle;
  // clock suspend: whole engine and read pipe freeze while clock enable was low
  wire pipe_adv  = fifo_in_ready && cmd_ok;
  wire beat_adv  = busy_q && cmd_ok && (!rd_burst_q || pipe_adv);
  wire last_beat = beat_adv && (cnt_q == 8'h00);
  wire issue_rd  = beat_adv && rd_burst_q && !stop_any;

  genvar g;
  for (g = 0; g < NB; g++)
  begin : g_bank
    sbc_pkg::sbc_state_e st_q;
    sbc_pkg::sbc_state_e st_d;
    sbc_pkg::sbc_state_e rw_st;
    logic [3:0]          tmr_q;
    logic [3:0]          tmr_d;
    logic                ill_d;
    logic                start_d;

    wire hit     = (bank_select_bit == 1'(g));
    wire pre_hit = precharge_cmd && (autoprecharge_bit || hit);
    wire eng     = busy_q && (bbank_q == 1'(g));
    wire done    = eng && (last_beat || (start_any && !start_d));
    wire in_burst = (st_q == sbc_pkg::SBC_READ) || (st_q == sbc_pkg::SBC_WRITE);

    assign stop_w[g]  = cmd_ok && eng && in_burst && (burst_stop_cmd || pre_hit);
    assign st_w[g]    = st_q;
    assign ill_w[g]   = ill_d;
    assign start_w[g] = start_d;
    assign done_w[g]  = done;
    assign bank_state[g*4 +: 4] = st_q;

    always_comb
    begin
      st_d    = st_q;
      tmr_d   = (tmr_q != 4'h0) ? tmr_q - 4'h1 : 4'h0;
      ill_d   = 1'b0;
      start_d = 1'b0;
      if (read_cmd)
        rw_st = autoprecharge_bit ? sbc_pkg::SBC_READ_AP : sbc_pkg::SBC_READ;
      else
        rw_st = autoprecharge_bit ? sbc_pkg::SBC_WRITE_AP : sbc_pkg::SBC_WRITE;
      if (cmd_ok)
      begin
        case (st_q)
          sbc_pkg::SBC_IDLE:
          begin
            if (bank_activate_cmd && hit)
              st_d = sbc_pkg::SBC_ACTIVE;
            else if (rw_cmd && hit)
              ill_d = 1'b1;
            else if (refresh_cmd && all_idle)
            begin
              st_d  = sbc_pkg::SBC_REFRESH;
              tmr_d = sbc_pkg::SBC_REF_CYC;
            end
          end
          sbc_pkg::SBC_ACTIVE:
          begin
            if (rw_cmd && hit)
            begin
              st_d    = rw_st;
              start_d = 1'b1;
            end
            else if (pre_hit)
            begin
              st_d  = sbc_pkg::SBC_PRECHARGE;
              tmr_d = sbc_pkg::SBC_PRE_CYC;
            end
            else if (bank_activate_cmd && hit)
              ill_d = 1'b1;
          end
          sbc_pkg::SBC_READ, sbc_pkg::SBC_WRITE:
          begin
            if (done && st_q == sbc_pkg::SBC_READ)
              st_d = sbc_pkg::SBC_ACTIVE;
            else if (done)
            begin
              st_d  = sbc_pkg::SBC_WR_RECOV;
              tmr_d = sbc_pkg::SBC_RECOV_CYC;
            end
            if (burst_stop_cmd && eng)
              st_d = sbc_pkg::SBC_ACTIVE;
            else if (rw_cmd && hit)
            begin
              st_d    = rw_st;
              start_d = 1'b1;
            end
            else if (pre_hit)
            begin
              st_d  = sbc_pkg::SBC_PRECHARGE;
              tmr_d = sbc_pkg::SBC_PRE_CYC;
            end
            else if (bank_activate_cmd && hit)
              ill_d = 1'b1;
          end
          sbc_pkg::SBC_READ_AP, sbc_pkg::SBC_WRITE_AP:
          begin
            if (done)
            begin
              st_d  = (st_q == sbc_pkg::SBC_READ_AP) ? sbc_pkg::SBC_PRECHARGE
                                                     : sbc_pkg::SBC_WR_RECOV_AP;
              tmr_d = (st_q == sbc_pkg::SBC_READ_AP) ? sbc_pkg::SBC_PRE_CYC
                                                     : sbc_pkg::SBC_RECOV_CYC;
            end
            if (((rw_cmd || bank_activate_cmd) && hit) || pre_hit || burst_stop_cmd)
              ill_d = 1'b1;
          end
          sbc_pkg::SBC_WR_RECOV:
          begin
            if (rw_cmd && hit)
            begin
              st_d    = rw_st;
              start_d = 1'b1;
            end
            else if ((bank_activate_cmd && hit) || pre_hit)
              ill_d = 1'b1;
            else if (tmr_q == 4'h0)
              st_d = sbc_pkg::SBC_ACTIVE;
          end
          sbc_pkg::SBC_WR_RECOV_AP, sbc_pkg::SBC_PRECHARGE:
          begin
            if ((rw_cmd || bank_activate_cmd) && hit)
              ill_d = 1'b1;
            else if (tmr_q == 4'h0 && st_q == sbc_pkg::SBC_PRECHARGE)
              st_d = sbc_pkg::SBC_IDLE;
            else if (tmr_q == 4'h0)
            begin
              st_d  = sbc_pkg::SBC_PRECHARGE;
              tmr_d = sbc_pkg::SBC_PRE_CYC;
            end
          end
          sbc_pkg::SBC_REFRESH:
          begin
            if (tmr_q == 4'h0 && !self_refresh)
              st_d = sbc_pkg::SBC_IDLE;
          end
          default:
            st_d = sbc_pkg::SBC_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        st_q  <= sbc_pkg::SBC_IDLE;
        tmr_q <= 4'h0;
      end
      else
      begin
        st_q  <= st_d;
        tmr_q <= tmr_d;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q     <= 1'b0;
      rd_burst_q <= 1'b0;
      bbank_q    <= 1'b0;
      col_q      <= '0;
      cnt_q      <= 8'h00;
    end
    else if (start_any)
    begin
      busy_q     <= 1'b1;
      rd_burst_q <= read_cmd;
      bbank_q    <= bank_select_bit;
      col_q      <= col_s;
      cnt_q      <= 8'(BURST_LEN - 1);
    end
    else if (stop_any)
      busy_q <= 1'b0;
    else if (beat_adv)
    begin
      // plain sequential increment; wrap order within the burst is not modelled
      col_q  <= col_q + 1'b1;
      cnt_q  <= cnt_q - 8'h01;
      busy_q <= (cnt_q != 8'h00);
    end
  end

  // beats already issued drain through the latency pipe after a stop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CAS_LAT; i++)
      begin
        pipe_v_q[i] <= 1'b0;
        pipe_d_q[i] <= '0;
      end
    end
    else if (pipe_adv)
    begin
      pipe_v_q[0] <= issue_rd;
      pipe_d_q[0] <= {bbank_q, col_q};
      for (int i = 1; i < CAS_LAT; i++)
      begin
        pipe_v_q[i] <= pipe_v_q[i-1];
        pipe_d_q[i] <= pipe_d_q[i-1];
      end
    end
  end

  sbc_fifo #(
    .WIDTH (DW),
    .DEPTH (sbc_pkg::SBC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (pipe_v_q[CAS_LAT-1] && cmd_ok),
    .in_ready  (fifo_in_ready),
    .in_data   (pipe_d_q[CAS_LAT-1]),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      illegal_cmd  <= 1'b0;
      power_down   <= 1'b0;
      self_refresh <= 1'b0;
      mode_reg     <= '0;
      burst_busy   <= 1'b0;
    end
    else
    begin
      illegal_cmd <= ill_w[0] || ill_w[1] || ill_glob;
      burst_busy  <= busy_q;
      if (cmd_ok && mode_register_load_cmd && all_idle)
        mode_reg <= addr_s;
      if (cmd_ok && !cke_s && quiet_cmd && all_idle)
        power_down <= 1'b1;
      else if (cke_s)
        power_down <= 1'b0;
      if (cmd_ok && !cke_s && refresh_cmd && all_idle)
        self_refresh <= 1'b1;
      else if (cke_s)
        self_refresh <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire hit0 = (bank_select_bit == 1'b0);

  AST_IDLE_RW_ILLEGAL: assert property (cmd_ok && rw_cmd && hit0 && st_w[0] == sbc_pkg::SBC_IDLE
    |=> illegal_cmd && st_w[0] == sbc_pkg::SBC_IDLE) else $error("read or write in idle not flagged");
  AST_READ_DONE: assert property (cmd_ok && st_w[0] == sbc_pkg::SBC_READ && done_w[0]
    && (device_deselect_cmd || nop_cmd) |=> st_w[0] == sbc_pkg::SBC_ACTIVE) else $error("read end not active");
  AST_READ_STOP: assert property (stop_w[0] && burst_stop_cmd
    |=> st_w[0] == sbc_pkg::SBC_ACTIVE && !busy_q) else $error("burst stop missed on read");
  AST_READ_RESTART: assert property (cmd_ok && read_cmd && hit0 && st_w[0] == sbc_pkg::SBC_READ
    |=> busy_q && rd_burst_q && col_q == $past(col_s)) else $error("read restart wrong column");
  AST_READ_TO_WRITE: assert property (cmd_ok && write_cmd && hit0 && st_w[0] == sbc_pkg::SBC_READ
    |=> busy_q && !rd_burst_q) else $error("write did not interrupt read");
  AST_READ_PRE: assert property (cmd_ok && precharge_both_cmd && st_w[0] == sbc_pkg::SBC_READ
    |=> st_w[0] == sbc_pkg::SBC_PRECHARGE) else $error("precharge during read missed");
  AST_WRITE_DONE: assert property (cmd_ok && st_w[0] == sbc_pkg::SBC_WRITE && last_beat && bbank_q == 1'b0
    && nop_cmd |=> st_w[0] == sbc_pkg::SBC_WR_RECOV) else $error("write end not recovery");
  AST_WRITE_STOP: assert property (stop_w[0] && burst_stop_cmd && !rd_burst_q
    |=> st_w[0] == sbc_pkg::SBC_ACTIVE) else $error("burst stop missed on write");
  AST_AP_BST_ILLEGAL: assert property (cmd_ok && burst_stop_cmd && st_w[0] == sbc_pkg::SBC_READ_AP
    |=> illegal_cmd ##1 1'b1) else $error("burst stop in read ap not flagged");
  AST_PIPE_DRAIN: assert property (stop_any && rd_burst_q && pipe_v_q[0] && pipe_adv |=> pipe_v_q[1])
    else $error("read beat lost before latency");
  AST_ACT_OPENS: assert property (cmd_ok && bank_activate_cmd && hit0 && st_w[0] == sbc_pkg::SBC_IDLE
    |=> st_w[0] == sbc_pkg::SBC_ACTIVE) else $error("activate did not open row");
  AST_DESEL_QUIET: assert property (cmd_ok && device_deselect_cmd |=> !illegal_cmd)
    else $error("deselect flagged illegal");

  COV_READ_BURST: cover property (st_w[0] == sbc_pkg::SBC_READ ##[1:8] st_w[0] == sbc_pkg::SBC_ACTIVE);
  COV_WRITE_RECOV: cover property (st_w[1] == sbc_pkg::SBC_WR_RECOV);
  COV_RD_AP: cover property (st_w[0] == sbc_pkg::SBC_READ_AP ##[1:8] st_w[0] == sbc_pkg::SBC_PRECHARGE);
  COV_FIFO_FULL: cover property (!fifo_in_ready);

endmodule

// ==== hdl/sbc_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides and a registered output stage.
  Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module sbc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;

  wire push = in_valid && in_ready;
  // output stage refills whenever memory holds a word and the stage is empty or being drained
  wire load = (cnt_q != '0) && (!out_valid || out_ready);

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (load)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data <= mem_q[rd_ptr_q];
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      if (load)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

endmodule

// ==== hdl/sbc_pkg.sv ====
/*
  Shared constants and state encoding for the two-bank command-legality block.
  Assumes the single system clock and no bus; pin widths fixed by the device.
*/
package sbc_pkg;

  localparam int SBC_NUM_BANKS = 2;
  localparam int SBC_ADDR_W    = 12;
  localparam int SBC_BANK_BIT  = 11;
  localparam int SBC_AP_BIT    = 10;
  localparam int SBC_COL_W     = 8;
  localparam int SBC_STATE_W   = 4;

  // defaults of module parameters; no figure is given, plain values
  localparam int SBC_DEF_BURST_LEN = 4;
  localparam int SBC_DEF_CAS_LAT   = 2;
  localparam int SBC_FIFO_DEPTH    = 16;

  // internal delays of the states handled only as exits
  localparam logic [3:0] SBC_PRE_CYC   = 4'h2;
  localparam logic [3:0] SBC_RECOV_CYC = 4'h2;
  localparam logic [3:0] SBC_REF_CYC   = 4'h4;

  typedef enum logic [3:0] {
    SBC_IDLE        = 4'h0,
    SBC_ACTIVE      = 4'h1,
    SBC_READ        = 4'h2,
    SBC_WRITE       = 4'h3,
    SBC_READ_AP     = 4'h4,
    SBC_WRITE_AP    = 4'h5,
    SBC_WR_RECOV    = 4'h6,
    SBC_WR_RECOV_AP = 4'h7,
    SBC_PRECHARGE   = 4'h8,
    SBC_REFRESH     = 4'h9
  } sbc_state_e;

endpackage

// ==== verif/sbc_ctrl_model.sv ====
/*
  Far-side model: the memory controller that drives the command pins.
  Assumes the bench calls its tasks; pins change only at falling edges.
*/
`timescale 1ns/1ps
module sbc_ctrl_model (
  input  wire logic        clk,
  output logic             cke_pin,
  output logic             cs_n_pin,
  output logic [2:0]       rcw_n,
  output logic [11:0]      addr_pin
);
  initial
  begin
    cke_pin = 1'b1;
    cs_n_pin = 1'b1;
    rcw_n = 3'h7;
    addr_pin = 12'h000;
  end
  // strobes and address held together for one edge
  task automatic issue(input logic [2:0] c, input logic [11:0] a);
    @(negedge clk);
    cs_n_pin = 1'b0;
    rcw_n = c;
    addr_pin = a;
  endtask
  // deselected pins carry no stale value
  task automatic idle();
    @(negedge clk);
    cs_n_pin = 1'b1;
    rcw_n = ~rcw_n;
    addr_pin = ~addr_pin;
  endtask
  // enable stays low as long as power-down lasts
  task automatic set_cke(input logic v);
    @(negedge clk);
    cke_pin = v;
  endtask
endmodule

// ==== verif/tb.sv ====
/*
  Self-checking bench of the bank command block, with a state model.
  Assumes the controller model in its own file; read sink in the bench.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] mode_register_load_cmd = 3'h0;
  localparam logic [2:0] refresh_cmd            = 3'h1;
  localparam logic [2:0] precharge_cmd          = 3'h2;
  localparam logic [2:0] bank_activate_cmd      = 3'h3;
  localparam logic [2:0] write_cmd              = 3'h4;
  localparam logic [2:0] read_cmd               = 3'h5;
  localparam logic [2:0] burst_stop_cmd         = 3'h6;
  localparam logic [2:0] nop_cmd                = 3'h7;
  localparam int         BL                     = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd_ready = 1'b0;
  logic        hold = 1'b0;
  logic        cke_pin, cs_n_pin, rd_valid, illegal_cmd, power_down, self_refresh, burst_busy;
  logic [2:0]  rcw_n;
  logic [11:0] addr_pin, mode_reg;
  logic [8:0]  rd_data;
  logic [7:0]  bank_state, col, col2;
  logic [31:0] lfsr = 32'h0001_5A7B;
  logic [8:0]  got[$];
  logic [2:0]  bad[6] = '{burst_stop_cmd, read_cmd, write_cmd, bank_activate_cmd, precharge_cmd,
                          mode_register_load_cmd};
  int          n_errors = 0;
  int          total_checks = 0;
  int          st[2] = '{0, 0};
  bit          ill;

  always #20 clk = ~clk;

  sbc_ctrl_model ctrl (.clk(clk), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .rcw_n(rcw_n), .addr_pin(addr_pin));
  sbc_bank_ctrl #(.BURST_LEN(BL), .CAS_LAT(2)) dut (
    .clk(clk), .rst_n(rst_n), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .ras_n_pin(rcw_n[2]),
    .cas_n_pin(rcw_n[1]), .we_n_pin(rcw_n[0]), .addr_pin(addr_pin), .rd_ready(rd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .bank_state(bank_state), .illegal_cmd(illegal_cmd),
    .power_down(power_down), .self_refresh(self_refresh), .mode_reg(mode_reg), .burst_busy(burst_busy));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // sink stalls at random, or fully while hold is set
  always @(negedge clk)
  begin
    lfsr <= lfsr_next(lfsr);
    rd_ready <= !hold && lfsr[3];
  end
  always @(posedge clk)
    if (rd_valid && rd_ready)
      got.push_back(rd_data);

  function automatic int nxt(input int s, input logic [2:0] c, input logic ap, output bit il);
    il = 1'b0;
    nxt = s;
    if (s == 0)
    begin
      if (c == bank_activate_cmd)
        nxt = 1;
      else
        il = (c == read_cmd || c == write_cmd);
    end
    else if (s == 4)
      il = (c != nop_cmd);
    else if (c == read_cmd)
      nxt = ap ? 4 : 2;
    else if (c == write_cmd)
      nxt = ap ? 5 : 3;
    else if (c == precharge_cmd)
      nxt = 8;
    else if (c == burst_stop_cmd)
      nxt = 1;
    else
      il = (c != nop_cmd);
  endfunction

  task automatic check_val(input logic [11:0] g, input logic [11:0] e, input string m);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic check_state();
    check_val({4'h0, bank_state}, {4'h0, st[1][3:0], st[0][3:0]}, "bank state");
  endtask
  task automatic cmd(input logic [2:0] c, input int b, input logic ap, input logic [7:0] cl);
    ctrl.issue(c, {b[0], ap, 2'h0, cl});
    st[b] = nxt(st[b], c, ap, ill);
  endtask
  // result registers on the second edge after the pins are sampled; the flag pulse lasts one cycle
  task automatic chk();
    ctrl.idle();
    repeat (2) @(posedge clk);
    #1;
    check_state();
    check_val({11'h0, illegal_cmd}, {11'h0, ill}, "illegal flag");
  endtask
  task automatic wait_st(input int b, input int e);
    int n;
    n = 0;
    while (bank_state[b*4+:4] !== e[3:0] && n < 80)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    st[b] = e;
    check_state();
  endtask
  task automatic wait_pd(input logic e);
    int n;
    n = 0;
    while (power_down !== e && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check_val({11'h0, power_down}, {11'h0, e}, "power down");
  endtask
  task automatic drain();
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    while (rd_valid !== 1'b0 && n < 80)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    cmd(nop_cmd, 0, 0, 0);
    cmd(burst_stop_cmd, 0, 0, 0);
    chk();
    cmd(read_cmd, 0, 0, 5);
    chk();
    cmd(precharge_cmd, 0, 0, 0);
    chk();
    cmd(mode_register_load_cmd, 0, 0, 8'h23);
    chk();
    check_val(mode_reg, 12'h023, "mode");
    cmd(refresh_cmd, 0, 0, 0);
    ctrl.cke_pin = 1'b0;
    st = '{9, 9};
    chk();
    check_val({11'h0, self_refresh}, 12'h001, "self refresh");
    ctrl.set_cke(1'b1);
    st[1] = 0;
    wait_st(0, 0);
    check_val({11'h0, self_refresh}, 12'h000, "self refresh exit");
    ctrl.set_cke(1'b0);
    wait_pd(1'b1);
    ctrl.set_cke(1'b1);
    wait_pd(1'b0);
    $display("test idle done");
    cmd(bank_activate_cmd, 1, 0, 0);
    chk();
    cmd(bank_activate_cmd, 0, 0, 0);
    chk();
    col = {1'b0, lfsr[10:4]};
    col2 = {1'b0, lfsr[18:12]};
    got.delete();
    cmd(read_cmd, 0, 0, col);
    chk();
    @(posedge clk);
    #1;
    check_val({11'h0, burst_busy}, 12'h001, "burst busy");
    wait_st(0, 1);
    drain();
    check_val(got.size(), BL, "beat count");
    for (int i = 0; i < BL; i++)
      check_val({3'h0, got[i]}, {4'h0, col + 8'(i)}, "beat");
    got.delete();
    cmd(read_cmd, 0, 0, col);
    cmd(read_cmd, 0, 0, col2);
    chk();
    wait_st(0, 1);
    drain();
    for (int i = 0; i < BL; i++)
      check_val({3'h0, got[got.size() - BL + i]}, {4'h0, col2 + 8'(i)}, "restart beat");
    $display("test read done");
    cmd(read_cmd, 0, 0, col);
    cmd(burst_stop_cmd, 0, 0, 0);
    chk();
    cmd(write_cmd, 0, 0, col);
    cmd(burst_stop_cmd, 0, 0, 0);
    chk();
    cmd(read_cmd, 0, 0, col);
    cmd(write_cmd, 0, 0, col2);
    chk();
    cmd(write_cmd, 0, 0, col);
    chk();
    wait_st(0, 6);
    wait_st(0, 1);
    cmd(write_cmd, 0, 0, col);
    cmd(read_cmd, 0, 0, col2);
    cmd(bank_activate_cmd, 0, 0, 0);
    chk();
    cmd(precharge_cmd, 0, 0, 0);
    chk();
    wait_st(0, 0);
    cmd(bank_activate_cmd, 0, 0, 0);
    cmd(write_cmd, 0, 0, col);
    cmd(precharge_cmd, 0, 0, 0);
    chk();
    wait_st(0, 0);
    $display("test interrupt done");
    foreach (bad[i])
    begin
      cmd(bank_activate_cmd, 0, 0, 0);
      cmd(read_cmd, 0, 1, col);
      cmd(bad[i], 0, 0, col2);
      chk();
      wait_st(0, 8);
      wait_st(0, 0);
    end
    $display("test auto precharge done");
    // five bursts overflow 16 words plus output stage; nothing may be lost
    drain();
    cmd(bank_activate_cmd, 0, 0, 0);
    got.delete();
    hold = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      cmd(read_cmd, 0, 0, col);
      ctrl.idle();
      repeat (30) @(posedge clk);
    end
    hold = 1'b0;
    wait_st(0, 1);
    drain();
    check_val(got.size(), 5 * BL, "buffered beats");
    $display("test buffer done");
    final_report();
  end

  initial
  begin
    #(40 * 30000);
    n_errors++;
    final_report();
  end
endmodule
